// [hdl/pwrup_cmd_rx.sv]
// shared constants of the power-up sequencer, and the command frame receiver
// assumes: one system clock, command line and bus clock already synchronised
package pwrup_pkg;
    // --------------------------------------------------------------
    // register map (byte addresses) and fields
    // --------------------------------------------------------------
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_STAT      = 8'h04;
    localparam logic [7:0]  A_DRV       = 8'h08;
    localparam logic [7:0]  A_OCR       = 8'h0C;
    localparam int          CTRL_SEL    = 0;
    localparam int          CTRL_ACK    = 1;
    localparam int          CTRL_BSUP   = 2;
    localparam int          CTRL_LEG    = 3;
    localparam logic [3:0]  CTRL_RST    = 4'h4;
    localparam logic [31:0] OCR_RST     = 32'h00FF8080;
    localparam logic [15:0] DRV_RST     = 16'h0000;
    localparam int          DRV_SPD_LSB = 0;
    localparam int          DRV_STR_LSB = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // --------------------------------------------------------------
    // command line protocol
    // --------------------------------------------------------------
    localparam logic [5:0]  IDX_RESET       = 6'h00;
    localparam logic [5:0]  IDX_OPCOND      = 6'h01;
    localparam logic [31:0] BOOT_ARG        = 32'hFFFFFFFA;
    localparam int          FRAME_BITS      = 48;
    localparam int          BOOT_LOW_CLOCKS = 74;
    localparam logic [2:0]  ACK_PAT         = 3'h2;
    localparam int          RESP_GAP_CLOCKS = 2;
    localparam int          ACK_GAP_CLOCKS  = 2;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int SYS_CLK_HZ        = 50_000_000;
    localparam int INIT_LIMIT_MS     = 1000;
    localparam int INIT_LIMIT_CYCLES = SYS_CLK_HZ / 1000 * INIT_LIMIT_MS;
    typedef enum logic [2:0] {
        ST_PRE_IDLE = 3'b000,
        ST_IDLE     = 3'b001,
        ST_PRE_BOOT = 3'b010,
        ST_BOOT     = 3'b011,
        ST_IDENT    = 3'b100
    } state_e;
endpackage

module cmd_frame_rx (
    // clock and control
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        en,
    // sampled line
    input  wire logic        sample,
    input  wire logic        cmd_bit,
    // decoded frame
    output logic             frame_ok,
    output logic [5:0]       idx,
    output logic [31:0]      arg
);
    import pwrup_pkg::*;
    logic        armed_q;
    logic        busy_q;
    logic [5:0]  cnt_q;
    logic [45:0] sh_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q  <= 1'b0;
            busy_q   <= 1'b0;
            cnt_q    <= 6'h00;
            sh_q     <= 46'h0;
            frame_ok <= 1'b0;
            idx      <= 6'h00;
            arg      <= 32'h0;
        end else if (ce) begin
            frame_ok <= 1'b0;
            if (!en) begin
                busy_q  <= 1'b0;
                armed_q <= 1'b0;
            end else if (sample && !busy_q) begin
                // a frame starts only on a low after a high
                if (cmd_bit) armed_q <= 1'b1;
                else if (armed_q) begin
                    busy_q <= 1'b1;
                    cnt_q  <= 6'h01;
                end
            end else if (sample) begin
                sh_q  <= {sh_q[44:0], cmd_bit};
                cnt_q <= cnt_q + 6'h01;
                // direction bit low: not a host command, wait for high
                if (cnt_q == 6'h01 && !cmd_bit) begin
                    busy_q  <= 1'b0;
                    armed_q <= 1'b0;
                end else if (cnt_q == 6'(FRAME_BITS - 1)) begin
                    busy_q   <= 1'b0;
                    frame_ok <= cmd_bit;
                    idx      <= sh_q[44:39];
                    arg      <= sh_q[38:7];
                end
            end
        end
    end
endmodule

// [hdl/pwrup_boot_seq.sv]
// power-up, pre-boot and boot entry sequencer of a managed flash device
// assumes: AXI4-Lite master on I_CLK_SYS, bus clock and command line from pins
// Functional notes
// [R01] after reset the device sits in pre-idle before any other state
// [R02] no boot support or select flag clear: pre-idle goes straight to idle
// [R03] in idle every frame except CMD1 is ignored; CMD1 is answered
// [R04] legacy-revision mode never enters pre-boot, only idle
// [R05] select flag set: pre-idle goes to pre-boot and waits for boot start
// [R06] 74 low bus clocks or CMD0 with FFFFFFFA in pre-boot start boot
// [R07] any other frame in pre-boot, except CMD1, sends the device to idle
// [R08] acknowledge enabled: pattern 010 is sent after boot starts
// [R09] boot termination returns to idle, ready for CMD1
// [R10] CMD1 in pre-boot is answered and leads to identification
// [R11] CMD1 answer carries voltage profile and busy flag until init ends
// [R12] init completes within 1 second of first CMD1 with valid range
// [R13] host sends CMD1 only with supply at its advertised level
// [R14] host starts clock and sends initialising sequence after power-up
// [R15] initialising sequence adds 10 clocks over the 64 power-up clocks
// [R16] every host issues CMD1 for voltage and readiness polling
// [R17] host issues commands only once both supplies are stable
// [R18] host restores core supply before wake command after sleep
// [R19] driver-stage register: bits 0-7 speed, bits 8-15 drive strength
// [R20] any speed and strength combination is accepted
// [R21] low bus clocks are counted consecutively, restart on a high
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
module pwrup_boot_seq #(
    parameter int INIT_CYCLES = pwrup_pkg::INIT_LIMIT_CYCLES
) (
    // clock, reset, enable
    input  wire logic                   I_CLK_SYS,
    input  wire logic                   I_RESETN,
    input  wire logic                   I_CE,
    // axi4-lite write
    input  wire logic [7:0]             I_AWADDR,
    input  wire logic                   I_AWVALID,
    output logic                        O_AWREADY,
    input  wire logic [31:0]            I_WDATA,
    input  wire logic [3:0]             I_WSTRB,
    input  wire logic                   I_WVALID,
    output logic                        O_WREADY,
    output logic [1:0]                  O_BRESP,
    output logic                        O_BVALID,
    input  wire logic                   I_BREADY,
    // axi4-lite read
    input  wire logic [7:0]             I_ARADDR,
    input  wire logic                   I_ARVALID,
    output logic                        O_ARREADY,
    output logic [31:0]                 O_RDATA,
    output logic [1:0]                  O_RRESP,
    output logic                        O_RVALID,
    input  wire logic                   I_RREADY,
    // link pins
    input  wire logic                   I_BUS_CLK,
    input  wire logic                   I_CMD_IN,
    output logic                        O_CMD_OUT,
    output logic                        O_CMD_OE_N,
    output logic                        O_DAT0_OUT,
    output logic                        O_DAT0_OE_N,
    // status
    output pwrup_pkg::state_e           O_STATE,
    output logic                        O_BUSY,
    output logic                        O_BOOT_ACTIVE,
    output logic [7:0]                  O_DRV_SPEED,
    output logic [7:0]                  O_DRV_STRENGTH
);
    import pwrup_pkg::*;

    function automatic logic [31:0] merge_w(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
        merge_w = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) merge_w[8*b+:8] = new_v[8*b+:8];
        end
    endfunction

    // --------------------------------------------------------------
    // pin synchronisers and edge detection
    // --------------------------------------------------------------
    logic [2:0] bclk_s_q;
    logic [1:0] cmd_s_q;
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            bclk_s_q <= 3'h0;
            cmd_s_q  <= 2'h3;
        end else if (I_CE) begin
            bclk_s_q <= {bclk_s_q[1:0], I_BUS_CLK};
            cmd_s_q  <= {cmd_s_q[0], I_CMD_IN};
        end
    end
    wire bclk_rise = bclk_s_q[1] & ~bclk_s_q[2];
    wire bclk_fall = ~bclk_s_q[1] & bclk_s_q[2];
    wire cmd_smp   = cmd_s_q[1];

    // --------------------------------------------------------------
    // axi4-lite slave
    // --------------------------------------------------------------
    logic        aw_q;
    logic        w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [3:0]  ctrl_q = CTRL_RST;
    logic [15:0] dsr_q;
    logic [31:0] ocr_q;
    logic        init_done_q;
    state_e      state_q;
    state_e      state_d;
    logic        boot_low_q;
    logic        boot_low_d;

    assign O_AWREADY = ~aw_q & ~O_BVALID;
    assign O_WREADY  = ~w_q & ~O_BVALID;
    assign O_ARREADY = ~O_RVALID;
    wire wr_fire = aw_q & w_q;
    wire wr_ctrl = wr_fire && awaddr_q == A_CTRL;
    wire wr_drv  = wr_fire && awaddr_q == A_DRV;
    wire wr_ocr  = wr_fire && awaddr_q == A_OCR;
    wire wr_ok   = wr_ctrl | wr_drv | wr_ocr;
    wire [31:0] ctrl_w = merge_w({28'h0, ctrl_q}, wdata_q, wstrb_q);
    wire [31:0] dsr_w  = merge_w({16'h0, dsr_q}, wdata_q, wstrb_q);
    wire [31:0] ocr_w  = merge_w(ocr_q, wdata_q, wstrb_q);
    wire rd_hit = I_ARADDR == A_CTRL || I_ARADDR == A_STAT || I_ARADDR == A_DRV || I_ARADDR == A_OCR;
    wire [31:0] rd_mux = (I_ARADDR == A_CTRL) ? {28'h0, ctrl_q} :
                         (I_ARADDR == A_STAT) ? {27'h0, O_BUSY, O_BOOT_ACTIVE, state_q} :
                         (I_ARADDR == A_OCR)  ? {init_done_q, ocr_q[30:0]} : 32'h0;

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
            O_BVALID <= 1'b0;
            O_BRESP  <= RESP_OKAY;
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h0;
            O_RRESP  <= RESP_OKAY;
        end else if (I_CE) begin
            if (I_AWVALID && O_AWREADY) begin
                aw_q     <= 1'b1;
                awaddr_q <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_q     <= 1'b1;
                wdata_q <= I_WDATA;
                wstrb_q <= I_WSTRB;
            end
            if (wr_fire) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (O_BVALID && I_BREADY) O_BVALID <= 1'b0;
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_mux;
                O_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (O_RVALID && I_RREADY) O_RVALID <= 1'b0;
        end
    end

    // boot config outlives reset, like the stored flag it stands for
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE && wr_ctrl) ctrl_q <= ctrl_w[3:0];
    end

    // registers; driver stage is write-only and takes any code pair
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            dsr_q  <= DRV_RST;
            ocr_q  <= OCR_RST;
        end else if (I_CE) begin
            if (wr_drv) dsr_q <= dsr_w[15:0]; // R20
            if (wr_ocr) ocr_q <= ocr_w;
        end
    end
    assign O_DRV_SPEED    = dsr_q[DRV_SPD_LSB+:8]; // R19
    assign O_DRV_STRENGTH = dsr_q[DRV_STR_LSB+:8]; // R19

    // --------------------------------------------------------------
    // command frames and boot-start detection
    // --------------------------------------------------------------
    logic        f_ok;
    logic [5:0]  f_idx;
    logic [31:0] f_arg;
    logic [6:0]  low_cnt_q;
    logic [47:0] tx_q;
    logic [5:0]  tx_left_q;
    logic [1:0]  tx_wait_q;
    wire tx_busy = tx_left_q != 6'h00 || ~O_CMD_OE_N;
    wire rx_en   = ~tx_busy & ~(state_q == ST_BOOT & boot_low_q);

    cmd_frame_rx u_rx (
        .clk      (I_CLK_SYS),
        .rst_n    (I_RESETN),
        .ce       (I_CE),
        .en       (rx_en),
        .sample   (bclk_rise),
        .cmd_bit  (cmd_smp),
        .frame_ok (f_ok),
        .idx      (f_idx),
        .arg      (f_arg)
    );

    wire cmd1     = f_ok && f_idx == IDX_OPCOND;
    wire cmd0     = f_ok && f_idx == IDX_RESET;
    wire boot_cmd = cmd0 && f_arg == BOOT_ARG;
    wire low_hit  = bclk_rise && !cmd_smp && low_cnt_q == 7'(BOOT_LOW_CLOCKS - 1);
    wire boot_go  = ctrl_q[CTRL_SEL] & ctrl_q[CTRL_BSUP] & ~ctrl_q[CTRL_LEG];
    wire boot_end = boot_low_q ? (bclk_rise & cmd_smp) : cmd0;
    wire answers  = state_q == ST_IDLE || state_q == ST_PRE_BOOT || state_q == ST_IDENT;
    wire respond  = cmd1 & answers;
    wire ocr_ok   = |(f_arg[23:0] & ocr_q[23:0]);

    // consecutive low clocks in pre-boot, cleared by any high
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) low_cnt_q <= 7'h00;
        else if (I_CE) begin
            if (state_q != ST_PRE_BOOT) low_cnt_q <= 7'h00;
            else if (bclk_rise) low_cnt_q <= cmd_smp ? 7'h00 : low_cnt_q + 7'h01; // R21
        end
    end

    // --------------------------------------------------------------
    // state machine
    // --------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        boot_low_d = boot_low_q;
        case (state_q)
            ST_PRE_IDLE: state_d = boot_go ? ST_PRE_BOOT : ST_IDLE; // R02 R04 R05
            ST_IDLE: begin
                if (cmd1) state_d = ST_IDENT; // R03
            end
            ST_PRE_BOOT: begin
                if (low_hit) begin
                    state_d    = ST_BOOT; // R06
                    boot_low_d = 1'b1;
                end else if (boot_cmd) begin
                    state_d    = ST_BOOT; // R06
                    boot_low_d = 1'b0;
                end else if (cmd1) state_d = ST_IDENT; // R10
                else if (f_ok) state_d = ST_IDLE; // R07
            end
            ST_BOOT: begin
                if (boot_end) state_d = ST_IDLE; // R09
            end
            ST_IDENT: state_d = ST_IDENT;
            default: state_d = ST_PRE_IDLE;
        endcase
    end
    wire boot_enter = state_q == ST_PRE_BOOT && state_d == ST_BOOT;

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q    <= ST_PRE_IDLE; // R01
            boot_low_q <= 1'b0;
        end else if (I_CE) begin
            state_q    <= state_d;
            boot_low_q <= boot_low_d;
        end
    end
    assign O_STATE       = state_q;
    assign O_BOOT_ACTIVE = state_q == ST_BOOT;
    assign O_BUSY        = ~init_done_q;

    // --------------------------------------------------------------
    // initialisation timer
    // --------------------------------------------------------------
    logic        init_run_q;
    logic [31:0] init_cnt_q;
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            init_run_q  <= 1'b0;
            init_done_q <= 1'b0;
            init_cnt_q  <= 32'h0;
        end else if (I_CE) begin
            if (respond && ocr_ok && !init_run_q && !init_done_q) init_run_q <= 1'b1;
            if (init_run_q) begin
                init_cnt_q <= init_cnt_q + 32'h1;
                if (init_cnt_q == 32'(INIT_CYCLES - 1)) begin
                    init_run_q  <= 1'b0; // R12
                    init_done_q <= 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // command response and boot acknowledge shifters
    // --------------------------------------------------------------
    logic [2:0] ack_q;
    logic [1:0] ack_left_q;
    logic [1:0] ack_wait_q;
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tx_q       <= 48'h0;
            tx_left_q  <= 6'h00;
            tx_wait_q  <= 2'h0;
            O_CMD_OUT  <= 1'b1;
            O_CMD_OE_N <= 1'b1;
        end else if (I_CE) begin
            if (respond) begin
                // busy flag sits in bit 31 of the conditions word
                tx_q      <= {2'h0, 6'h3F, init_done_q, ocr_q[30:0], 7'h7F, 1'b1}; // R11
                tx_left_q <= 6'(FRAME_BITS);
                tx_wait_q <= 2'(RESP_GAP_CLOCKS);
            end else if (bclk_rise && tx_wait_q != 2'h0) tx_wait_q <= tx_wait_q - 2'h1;
            else if (bclk_fall) begin
                if (tx_left_q != 6'h00 && tx_wait_q == 2'h0) begin
                    O_CMD_OUT  <= tx_q[47];
                    O_CMD_OE_N <= 1'b0;
                    tx_q       <= {tx_q[46:0], 1'b1};
                    tx_left_q  <= tx_left_q - 6'h01;
                end else O_CMD_OE_N <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_q       <= 3'h0;
            ack_left_q  <= 2'h0;
            ack_wait_q  <= 2'h0;
            O_DAT0_OUT  <= 1'b1;
            O_DAT0_OE_N <= 1'b1;
        end else if (I_CE) begin
            if (boot_enter && ctrl_q[CTRL_ACK]) begin
                ack_q      <= ACK_PAT; // R08
                ack_left_q <= 2'h3;
                ack_wait_q <= 2'(ACK_GAP_CLOCKS);
            end else if (bclk_rise && ack_wait_q != 2'h0) ack_wait_q <= ack_wait_q - 2'h1;
            else if (bclk_fall) begin
                if (ack_left_q != 2'h0 && ack_wait_q == 2'h0) begin
                    O_DAT0_OUT  <= ack_q[2];
                    O_DAT0_OE_N <= 1'b0;
                    ack_q       <= {ack_q[1:0], 1'b1};
                    ack_left_q  <= ack_left_q - 2'h1;
                end else O_DAT0_OE_N <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESETN || !I_CE);

    AST_NO_RETURN_PRE_IDLE: assert property (state_q != ST_PRE_IDLE |=> state_q != ST_PRE_IDLE) // R01
        else $error("pre-idle re-entered");
    AST_DIRECT_IDLE: assert property (state_q == ST_PRE_IDLE && !boot_go |=> state_q == ST_IDLE) // R02
        else $error("pre-idle did not go to idle");
    AST_LEGACY_NO_BOOT: assert property (ctrl_q[CTRL_LEG] && state_q == ST_PRE_IDLE |=> state_q != ST_PRE_BOOT) // R04
        else $error("legacy mode entered pre-boot");
    AST_PRE_BOOT_ENTRY: assert property (state_q == ST_PRE_IDLE && boot_go |=> state_q == ST_PRE_BOOT) // R05
        else $error("pre-boot not entered");
    AST_IDLE_IGNORES: assert property (state_q == ST_IDLE && f_ok && f_idx != IDX_OPCOND |=> state_q == ST_IDLE) // R03
        else $error("idle left on non-CMD1");
    AST_LOW_BOOT: assert property (state_q == ST_PRE_BOOT && low_hit |=> state_q == ST_BOOT && boot_low_q) // R06
        else $error("low hold did not start boot");
    AST_CMD0_BOOT: assert property (state_q == ST_PRE_BOOT && boot_cmd && !low_hit |=> state_q == ST_BOOT) // R06
        else $error("boot command ignored");
    AST_OTHER_IDLE: assert property (state_q == ST_PRE_BOOT && f_ok && !cmd1 && !boot_cmd && !low_hit
                                     |=> state_q == ST_IDLE) // R07
        else $error("pre-boot did not fall to idle");
    AST_ACK_FIRST_LOW: assert property ($fell(O_DAT0_OE_N) |-> !O_DAT0_OUT && ack_left_q == 2'h2) // R08
        else $error("acknowledge does not start with 0");
    AST_BOOT_END: assert property (state_q == ST_BOOT && boot_end |=> state_q == ST_IDLE) // R09
        else $error("boot end did not reach idle");
    AST_CMD1_IDENT: assert property (state_q == ST_PRE_BOOT && cmd1 |=> state_q == ST_IDENT
                                     && tx_left_q == 6'(FRAME_BITS)) // R10
        else $error("CMD1 in pre-boot not answered");
    AST_BUSY_BIT: assert property (respond |=> tx_q[39] == $past(init_done_q) && tx_q[47:40] == 8'h3F) // R11
        else $error("response busy flag wrong");
    AST_INIT_BOUND: assert property (init_run_q |-> init_cnt_q < 32'(INIT_LIMIT_CYCLES)) // R12
        else $error("initialisation overran limit");
    AST_DRV_FIELDS: assert property (wr_drv && wstrb_q[1:0] == 2'h3
                                     |=> {O_DRV_STRENGTH, O_DRV_SPEED} == $past(wdata_q[15:0])) // R19
        else $error("driver stage fields not stored");

    COV_LOW_BOOT: cover property (state_q == ST_PRE_BOOT && low_hit);
    COV_CMD_BOOT: cover property (state_q == ST_PRE_BOOT && boot_cmd);
    COV_IDENT: cover property (state_q == ST_PRE_BOOT && cmd1);
    COV_INIT_DONE: cover property ($rose(init_done_q));
endmodule

// [dv/host_model.sv]
// host side of the link: bus clock and open-drain command line
// assumes: line pulled up, device output enables low while it drives
module host_model (
    input  wire logic i_dev_out,
    input  wire logic i_dev_oe_n,
    output logic      o_bus_clk,
    output logic      o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        drv = 1'b1;
    logic [47:0] resp;
    int          nbits;
    assign o_cmd = drv & (i_dev_oe_n | i_dev_out);
    initial o_bus_clk = 1'b0;
    // one bus clock; clock stands still between calls
    task automatic tick(input logic b);
        o_bus_clk = 1'b1;
        #40;
        if (!i_dev_oe_n) begin
            resp = {resp[46:0], i_dev_out};
            nbits++;
        end
        #40 o_bus_clk = 1'b0;
        #40 drv = b;
        #40;
    endtask
    task automatic init_seq();
        repeat (74) tick(1'b1);
    endtask
    task automatic send(input logic [5:0] idx, input logic [31:0] arg);
        logic [47:0] f;
        f = {2'b01, idx, arg, 7'h7F, 1'b1};
        nbits = 0;
        for (int i = 47; i >= 0; i--) tick(f[i]);
        repeat (60) tick(1'b1);
    endtask
endmodule

// [dv/testbench.sv]
// self-checking bench: registers over AXI4-Lite, power-up states over the link
// assumes: host_model on the link pins, init count shortened
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pwrup_pkg::*;
    localparam int INIT = 2000;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, ce = 1;
    logic [2:0]  ack;
    logic [7:0]  awa = 0, ara = 0, spd, str;
    logic [31:0] wd = 0, rd, rdata;
    logic [1:0]  rr, bresp, rresp, t;
    logic        awr, wr_r, bv, arr, rv, bclk, cmd, co, coe, d0, d0e, busy, boot;
    logic [15:0] drv_v [2] = '{16'hA55A, 16'h00FF};
    state_e      state;
    int          errors, cmp_count, acks;
    pwrup_boot_seq #(.INIT_CYCLES(INIT)) dut_u (
        .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CE(ce), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr_r),
        .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv),
        .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rrdy),
        .I_BUS_CLK(bclk), .I_CMD_IN(cmd), .O_CMD_OUT(co), .O_CMD_OE_N(coe), .O_DAT0_OUT(d0),
        .O_DAT0_OE_N(d0e), .O_STATE(state), .O_BUSY(busy), .O_BOOT_ACTIVE(boot),
        .O_DRV_SPEED(spd), .O_DRV_STRENGTH(str));
    host_model host_u (.i_dev_out(co), .i_dev_oe_n(coe), .o_bus_clk(bclk), .o_cmd(cmd));
    always @(posedge bclk) if (!d0e) begin
        ack = {ack[1:0], d0};
        acks++;
    end
    initial forever #10 clk = ~clk;
    // ------------------------------------------------------------
    // bus tasks and verdict
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a;
        wd <= d;
        {awv, wv, brdy} <= 3'b111;
        do begin
            @(negedge clk);
            t = {awv & awr, wv & wr_r};
            @(posedge clk);
            if (t[1]) awv <= 1'b0;
            if (t[0]) wv <= 1'b0;
        end while (awv || wv);
        do @(negedge clk); while (!bv);
        r = bresp;
        @(posedge clk);
        brdy <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        {arv, rrdy} <= 2'b11;
        do @(negedge clk); while (!arr);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (!rv);
        {d, r} = {rdata, rresp};
        @(posedge clk);
        rrdy <= 1'b0;
    endtask
    task automatic pulse_rst();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        `CHK("state_rst", ST_PRE_IDLE, state)
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("state_idle", ST_IDLE, state)
        rdr(A_CTRL, rd, rr);
        `CHK("ctrl", {28'h0, CTRL_RST}, rd)
        rdr(A_STAT, rd, rr);
        `CHK("stat", {27'h0, 1'b1, 1'b0, ST_IDLE}, rd)
        wr(A_STAT, 32'h0, rr);
        `CHK("stat_wr", RESP_SLVERR, rr)
        rdr(8'h10, rd, rr);
        `CHK("unmapped", RESP_SLVERR, rr)
        foreach (drv_v[i]) begin
            wr(A_DRV, {16'h0, drv_v[i]}, rr);
            `CHK("drv_resp", RESP_OKAY, rr)
            `CHK("drv_spd", drv_v[i][7:0], spd)
            `CHK("drv_str", drv_v[i][15:8], str)
        end
        rdr(A_DRV, rd, rr);
        `CHK("drv_rd", 32'h0, rd)
        host_u.init_seq();
        host_u.send(IDX_RESET, BOOT_ARG);
        `CHK("idle_cmd0", ST_IDLE, state)
        `CHK("idle_quiet", 0, host_u.nbits)
        host_u.send(IDX_OPCOND, 32'h00FF8000);
        `CHK("ident", ST_IDENT, state)
        `CHK("resp_len", 48, host_u.nbits)
        `CHK("resp_head", 8'h3F, host_u.resp[47:40])
        `CHK("resp_busy", 1'b0, host_u.resp[39])
        `CHK("resp_ocr", OCR_RST[30:0], host_u.resp[38:8])
        `CHK("busy_on", 1'b1, busy)
        repeat (INIT) @(posedge clk);
        `CHK("busy_off", 1'b0, busy)
        host_u.send(IDX_OPCOND, 32'h00FF8000);
        `CHK("resp_ready", 1'b1, host_u.resp[39])
        rdr(A_OCR, rd, rr);
        `CHK("ocr_done", 1'b1, rd[31])
        wr(A_CTRL, 32'h7, rr);
        pulse_rst();
        `CHK("pre_boot", ST_PRE_BOOT, state)
        repeat (2) begin
            repeat (40) host_u.tick(1'b0);
            host_u.tick(1'b1);
        end
        `CHK("low_restart", ST_PRE_BOOT, state)
        acks = 0;
        repeat (80) host_u.tick(1'b0);
        `CHK("boot_low", ST_BOOT, state)
        `CHK("boot_act", 1'b1, boot)
        `CHK("ack", ACK_PAT, ack)
        `CHK("ack_len", 3, acks)
        repeat (2) host_u.tick(1'b1);
        `CHK("boot_end", ST_IDLE, state)
        pulse_rst();
        acks = 0;
        host_u.send(IDX_RESET, BOOT_ARG);
        `CHK("boot_cmd", ST_BOOT, state)
        `CHK("ack_cmd", 3, acks)
        host_u.send(IDX_RESET, 32'h0);
        `CHK("boot_cmd_end", ST_IDLE, state)
        pulse_rst();
        host_u.send(6'h08, 32'h0);
        `CHK("pre_boot_other", ST_IDLE, state)
        pulse_rst();
        host_u.send(IDX_OPCOND, 32'h00FF8000);
        `CHK("pre_boot_cmd1", ST_IDENT, state)
        `CHK("pre_boot_resp", 48, host_u.nbits)
        wr(A_CTRL, 32'hF, rr);
        ce <= 1'b0;
        pulse_rst();
        `CHK("ce_hold", ST_PRE_IDLE, state)
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("legacy", ST_IDLE, state)
        complete_run();
    end
endmodule
